// file: rtl/async_mem_pkg.sv
// Shared constants for the asynchronous memory phase sequencer
package async_mem_pkg;

  // Core clock period in ns
  localparam int CLK_PERIOD_NS = 10;

  // Wait pin timing, printed as multiples of the clock period
  localparam int WAIT_SETUP_E     = 4;
  localparam int WAIT_RELEASE_E   = 4;
  localparam int WAIT_PULSE_MIN_E = 2;
  localparam int WAIT_SETUP_NS    = WAIT_SETUP_E * CLK_PERIOD_NS;
  localparam int WAIT_RELEASE_NS  = WAIT_RELEASE_E * CLK_PERIOD_NS;
  localparam int WAIT_SETUP_CYC   = WAIT_SETUP_NS / CLK_PERIOD_NS;
  localparam int WAIT_RELEASE_CYC = WAIT_RELEASE_NS / CLK_PERIOD_NS;

  // Each external wait cycle is this many core clocks
  localparam int EXT_WAIT_UNIT = 16;

  // Pin synchroniser depth
  localparam int SYNC_STAGES = 2;

  // Field widths of the configuration inputs and internal counters
  localparam int SETUP_W  = 4;
  localparam int STROBE_W = 6;
  localparam int HOLD_W   = 3;
  localparam int TURN_W   = 2;
  localparam int LIMIT_W  = 8;
  localparam int CNT_W    = 8;
  localparam int SUB_W    = 4;

  // External bus widths
  localparam int ADDR_W = 21;
  localparam int BANK_W = 2;
  localparam int DATA_W = 16;
  localparam int CS_W   = 4;
  localparam int CSSEL_W = 2;

  // Reset values
  localparam logic       OUT_IDLE_N = 1'b1;
  localparam logic [7:0] CNT_RESET  = 8'h00;

  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_SETUP  = 7'h02,
    ST_STROBE = 7'h04,
    ST_WAIT   = 7'h08,
    ST_TAIL   = 7'h10,
    ST_HOLD   = 7'h20,
    ST_TURN   = 7'h40
  } seq_state_t;

endpackage

// file: rtl/async_memory_phase_sequencer.sv
// Setup, strobe and hold phase sequencer for an asynchronous memory port
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Read lasts setup plus strobe plus hold clocks without extended wait.
// - Extended read grows by sixteen clocks per external wait cycle.
// - Write lasts setup plus strobe plus hold clocks without extended wait.
// - Extended write grows by sixteen clocks per external wait cycle.
// - Address and bank valid for read setup clocks before read strobe falls.
// - Address and bank held read hold clocks after read strobe rises.
// - Read strobe low for strobe clocks, plus sixteen per wait cycle.
// - Chip select spans setup to hold, or follows read strobe if selected.
// - Address and bank valid write setup clocks before write strobe falls.
// - Address and bank held write hold clocks after write strobe rises.
// - In select-strobe mode chip select follows the write strobe.
// - Wait deadline measured to unextended hold start, ignoring wait cycles.
// - Strobe rises four clocks after the wait input is released.
// - Write strobe low for strobe clocks, plus sixteen per wait cycle.
// - Write data driven setup clocks before and hold clocks after strobe.
// - Extended waiting ends with a timeout at the wait limit.
// - Setup, strobe, hold, turnaround and wait limit come from configuration inputs; wait pin timing is fixed.
module async_memory_phase_sequencer #(
  parameter int ADDR_W  = async_mem_pkg::ADDR_W,
  parameter int DATA_W  = async_mem_pkg::DATA_W,
  parameter int CS_W    = async_mem_pkg::CS_W
) (
  input  wire logic                                 i_core_clk,
  input  wire logic                                 i_reset,
  // Access request from the core side
  input  wire logic                                 i_req_valid,
  input  wire logic                                 i_req_write,
  input  wire logic [ADDR_W-1:0]                    i_req_addr,
  input  wire logic [async_mem_pkg::BANK_W-1:0]     i_req_bank,
  input  wire logic [async_mem_pkg::CSSEL_W-1:0]    i_req_cs_sel,
  input  wire logic [DATA_W-1:0]                    i_req_wdata,
  output logic                                      o_req_ready,
  output logic [DATA_W-1:0]                         o_rdata,
  output logic                                      o_rdata_valid,
  output logic                                      o_wait_timeout,
  output logic                                      o_busy,
  // Configuration
  input  wire logic [async_mem_pkg::SETUP_W-1:0]    i_read_setup_cycles,
  input  wire logic [async_mem_pkg::STROBE_W-1:0]   i_read_strobe_cycles,
  input  wire logic [async_mem_pkg::HOLD_W-1:0]     i_read_hold_cycles,
  input  wire logic [async_mem_pkg::SETUP_W-1:0]    i_write_setup_cycles,
  input  wire logic [async_mem_pkg::STROBE_W-1:0]   i_write_strobe_cycles,
  input  wire logic [async_mem_pkg::HOLD_W-1:0]     i_write_hold_cycles,
  input  wire logic [async_mem_pkg::TURN_W-1:0]     i_turnaround_cycles,
  input  wire logic [async_mem_pkg::LIMIT_W-1:0]    i_max_wait_limit,
  input  wire logic                                 i_extend_wait_en,
  input  wire logic                                 i_select_strobe_en,
  // Memory pins
  input  wire logic                                 i_ext_wait_in,
  input  wire logic [DATA_W-1:0]                    i_mem_data_bus,
  output logic [DATA_W-1:0]                         o_mem_data_bus,
  output logic                                      o_mem_data_bus_oe_n,
  output logic [CS_W-1:0]                           o_chip_select_n,
  output logic                                      o_read_strobe_n,
  output logic                                      o_write_strobe_n,
  output logic [ADDR_W-1:0]                         o_mem_addr_out,
  output logic [async_mem_pkg::BANK_W-1:0]          o_bank_select_out
);

  localparam int CNT_W = async_mem_pkg::CNT_W;
  localparam int SUB_W = async_mem_pkg::SUB_W;
  localparam int LIM_W = async_mem_pkg::LIMIT_W;
  // Strobe cycles left when the synchronised wait is still in time
  localparam logic [CNT_W-1:0] WAIT_CHECK = CNT_W'(
    async_mem_pkg::WAIT_SETUP_CYC - async_mem_pkg::SYNC_STAGES);
  // Release tail: two clocks go to the synchroniser, one to the pin flop
  localparam logic [CNT_W-1:0] TAIL_M1 = CNT_W'(
    async_mem_pkg::WAIT_RELEASE_CYC - async_mem_pkg::SYNC_STAGES - 2);
  // Timeout keeps the strobe low two more clocks before hold
  localparam logic [CNT_W-1:0] TOUT_M1 = CNT_W'(
    async_mem_pkg::WAIT_RELEASE_CYC - async_mem_pkg::SYNC_STAGES - 1);
  localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(
    async_mem_pkg::EXT_WAIT_UNIT - 1);

  // A zero setup, strobe or hold field still gives a one-clock phase
  function automatic logic [CNT_W-1:0] len_m1(input logic [CNT_W-1:0] v);
    logic [CNT_W-1:0] r;
    r = (v == '0) ? '0 : v - CNT_W'(1);
    return r;
  endfunction

  // Pin synchronisers: wait and read data cross into the core clock
  logic wait_meta_reg;
  logic wait_sync_reg;
  logic [DATA_W-1:0] rd_meta_reg;
  logic [DATA_W-1:0] rd_sync_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      wait_meta_reg <= 1'b0;
      wait_sync_reg <= 1'b0;
      rd_meta_reg   <= '0;
      rd_sync_reg   <= '0;
    end else begin
      wait_meta_reg <= i_ext_wait_in;
      wait_sync_reg <= wait_meta_reg;
      rd_meta_reg   <= i_mem_data_bus;
      rd_sync_reg   <= rd_meta_reg;
    end
  end

  // Sequencer state
  async_mem_pkg::seq_state_t state_reg, state_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic [SUB_W-1:0]  sub_reg, sub_next;
  logic [LIM_W:0]    ewc_reg, ewc_next;
  logic              write_reg, write_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [async_mem_pkg::BANK_W-1:0] bank_reg, bank_next;
  logic [CS_W-1:0]   cs_onehot_reg, cs_onehot_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic              rvalid_reg, rvalid_next;
  logic              tout_reg, tout_next;
  logic              ready_reg, ready_next;
  logic              busy_reg, busy_next;
  logic [CS_W-1:0]   cs_n_reg, cs_n_next;
  logic              oe_n_reg, oe_n_next;
  logic              we_n_reg, we_n_next;
  logic              bus_oe_n_reg, bus_oe_n_next;
  logic [LIM_W:0]    limit_full;
  logic              strobe_ph;
  logic              span_ph;

  // Limit of zero stands for the full 256-cycle range
  assign limit_full = (i_max_wait_limit == '0) ?
                      {1'b1, {LIM_W{1'b0}}} : {1'b0, i_max_wait_limit};

  // Next state and phase counters
  always_comb begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    sub_next       = sub_reg;
    ewc_next       = ewc_reg;
    write_next     = write_reg;
    addr_next      = addr_reg;
    bank_next      = bank_reg;
    cs_onehot_next = cs_onehot_reg;
    wdata_next     = wdata_reg;
    rdata_next     = rdata_reg;
    rvalid_next    = 1'b0;
    tout_next      = 1'b0;
    case (state_reg)
      async_mem_pkg::ST_IDLE: begin
        if (i_req_valid && ready_reg) begin
          // Request latched so outputs stay put for the whole access
          write_next     = i_req_write;
          addr_next      = i_req_addr;
          bank_next      = i_req_bank;
          wdata_next     = i_req_wdata;
          cs_onehot_next = CS_W'(1) << i_req_cs_sel;
          ewc_next       = '0;
          sub_next       = '0;
          cnt_next       = i_req_write ?
                           len_m1(CNT_W'(i_write_setup_cycles)) :
                           len_m1(CNT_W'(i_read_setup_cycles));
          state_next     = async_mem_pkg::ST_SETUP;
        end
      end
      async_mem_pkg::ST_SETUP: begin
        if (cnt_reg == '0) begin
          cnt_next   = write_reg ?
                       len_m1(CNT_W'(i_write_strobe_cycles)) :
                       len_m1(CNT_W'(i_read_strobe_cycles));
          state_next = async_mem_pkg::ST_STROBE;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
      async_mem_pkg::ST_STROBE: begin
        // Synchronised wait seen in time for the unextended hold start
        if (i_extend_wait_en && wait_sync_reg &&
            cnt_reg < WAIT_CHECK) begin
          state_next = async_mem_pkg::ST_WAIT;
        end else if (cnt_reg == '0) begin
          cnt_next   = write_reg ?
                       len_m1(CNT_W'(i_write_hold_cycles)) :
                       len_m1(CNT_W'(i_read_hold_cycles));
          rdata_next = rd_sync_reg;
          rvalid_next = ~write_reg;
          state_next = async_mem_pkg::ST_HOLD;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
      async_mem_pkg::ST_WAIT: begin
        // Each 16 clocks of wait counts one external wait cycle
        sub_next = sub_reg + SUB_W'(1);
        if (sub_reg == SUB_LAST) begin
          ewc_next = ewc_reg + (LIM_W+1)'(1);
        end
        if (!wait_sync_reg) begin
          cnt_next   = TAIL_M1;
          state_next = async_mem_pkg::ST_TAIL;
        end else if (sub_reg == SUB_LAST &&
                     ewc_reg + (LIM_W+1)'(1) == limit_full) begin
          tout_next  = 1'b1;
          cnt_next   = TOUT_M1;
          state_next = async_mem_pkg::ST_TAIL;
        end
      end
      async_mem_pkg::ST_TAIL: begin
        if (cnt_reg == '0) begin
          cnt_next   = write_reg ?
                       len_m1(CNT_W'(i_write_hold_cycles)) :
                       len_m1(CNT_W'(i_read_hold_cycles));
          rdata_next = rd_sync_reg;
          rvalid_next = ~write_reg;
          state_next = async_mem_pkg::ST_HOLD;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
      async_mem_pkg::ST_HOLD: begin
        if (cnt_reg == '0) begin
          if (i_turnaround_cycles == '0) begin
            state_next = async_mem_pkg::ST_IDLE;
          end else begin
            cnt_next   = len_m1(CNT_W'(i_turnaround_cycles));
            state_next = async_mem_pkg::ST_TURN;
          end
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
      async_mem_pkg::ST_TURN: begin
        if (cnt_reg == '0) begin
          state_next = async_mem_pkg::ST_IDLE;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
      default: begin
        state_next = async_mem_pkg::ST_IDLE;
      end
    endcase
  end

  // Pin levels follow the next state so every pin is a flop output
  always_comb begin
    strobe_ph = (state_next == async_mem_pkg::ST_STROBE) ||
                (state_next == async_mem_pkg::ST_WAIT) ||
                (state_next == async_mem_pkg::ST_TAIL);
    span_ph   = strobe_ph ||
                (state_next == async_mem_pkg::ST_SETUP) ||
                (state_next == async_mem_pkg::ST_HOLD);
    oe_n_next = ~(strobe_ph && !write_next);
    we_n_next = ~(strobe_ph && write_next);
    // Select-strobe narrows chip select to the strobe window
    if (i_select_strobe_en) begin
      cs_n_next = strobe_ph ? ~cs_onehot_next : {CS_W{1'b1}};
    end else begin
      cs_n_next = span_ph ? ~cs_onehot_next : {CS_W{1'b1}};
    end
    // Write data driven across setup, strobe and hold
    bus_oe_n_next = ~(span_ph && write_next);
    ready_next    = (state_next == async_mem_pkg::ST_IDLE) &&
                    !(i_req_valid && ready_reg &&
                      state_reg == async_mem_pkg::ST_IDLE);
    busy_next     = ~ready_next;
  end

  // Register stage for the sequencer and its pins
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_reg     <= async_mem_pkg::ST_IDLE;
      cnt_reg       <= async_mem_pkg::CNT_RESET;
      sub_reg       <= '0;
      ewc_reg       <= '0;
      write_reg     <= 1'b0;
      addr_reg      <= '0;
      bank_reg      <= '0;
      cs_onehot_reg <= '0;
      wdata_reg     <= '0;
      rdata_reg     <= '0;
      rvalid_reg    <= 1'b0;
      tout_reg      <= 1'b0;
      ready_reg     <= 1'b0;
      busy_reg      <= 1'b1;
      cs_n_reg      <= {CS_W{async_mem_pkg::OUT_IDLE_N}};
      oe_n_reg      <= async_mem_pkg::OUT_IDLE_N;
      we_n_reg      <= async_mem_pkg::OUT_IDLE_N;
      bus_oe_n_reg  <= async_mem_pkg::OUT_IDLE_N;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      sub_reg       <= sub_next;
      ewc_reg       <= ewc_next;
      write_reg     <= write_next;
      addr_reg      <= addr_next;
      bank_reg      <= bank_next;
      cs_onehot_reg <= cs_onehot_next;
      wdata_reg     <= wdata_next;
      rdata_reg     <= rdata_next;
      rvalid_reg    <= rvalid_next;
      tout_reg      <= tout_next;
      ready_reg     <= ready_next;
      busy_reg      <= busy_next;
      cs_n_reg      <= cs_n_next;
      oe_n_reg      <= oe_n_next;
      we_n_reg      <= we_n_next;
      bus_oe_n_reg  <= bus_oe_n_next;
    end
  end

  // Address, bank and write data only change when a new access is latched
  assign o_mem_addr_out      = addr_reg;
  assign o_bank_select_out   = bank_reg;
  assign o_mem_data_bus      = wdata_reg;
  assign o_mem_data_bus_oe_n = bus_oe_n_reg;
  assign o_chip_select_n     = cs_n_reg;
  assign o_read_strobe_n     = oe_n_reg;
  assign o_write_strobe_n    = we_n_reg;
  assign o_req_ready         = ready_reg;
  assign o_rdata             = rdata_reg;
  assign o_rdata_valid       = rvalid_reg;
  assign o_wait_timeout      = tout_reg;
  // Busy has its own flop so the pin never sees an inverter glitch
  assign o_busy              = busy_reg;

endmodule
`default_nettype wire

// file: sim/async_mem_seq_sva.sv
// Assertion checker for the memory phase sequencer
`timescale 1ns/10ps
`default_nettype none
module async_mem_seq_sva (
  input wire logic        i_core_clk,
  input wire logic        i_reset,
  input wire logic [3:0]  i_read_setup_cycles,
  input wire logic [5:0]  i_read_strobe_cycles,
  input wire logic [2:0]  i_read_hold_cycles,
  input wire logic [3:0]  i_write_setup_cycles,
  input wire logic [5:0]  i_write_strobe_cycles,
  input wire logic [2:0]  i_write_hold_cycles,
  input wire logic        i_extend_wait_en,
  input wire logic        i_select_strobe_en,
  input wire logic        i_ext_wait_in,
  input wire logic        o_rdata_valid,
  input wire logic        o_wait_timeout,
  input wire logic [15:0] o_mem_data_bus,
  input wire logic        o_mem_data_bus_oe_n,
  input wire logic [3:0]  o_chip_select_n,
  input wire logic        o_read_strobe_n,
  input wire logic        o_write_strobe_n
);
  logic [7:0] cs_c, st_c, hd_c;
  logic       was_wr, cs_on, st_on;
  assign cs_on = ~&o_chip_select_n;
  assign st_on = !(o_read_strobe_n && o_write_strobe_n);
  // A zero phase field acts as one clock
  function automatic logic [7:0] e1(input logic [7:0] v);
    return (v == 8'h00) ? 8'h01 : v;
  endfunction
  // Clocks spent so far in select, strobe and hold
  always_ff @(posedge i_core_clk) begin
    cs_c <= (cs_on && !i_reset) ? cs_c + 8'h01 : 8'h00;
    st_c <= (st_on && !i_reset) ? st_c + 8'h01 : 8'h00;
    hd_c <= (st_on || !cs_on || i_reset) ? 8'h00 : hd_c + 8'h01;
    if (!o_write_strobe_n) was_wr <= 1'b1;
    else if (!o_read_strobe_n) was_wr <= 1'b0;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  sequence s_strobe_end;
    $rose(o_read_strobe_n && o_write_strobe_n);
  endsequence
  a_setup_len: assert property (
    $rose(st_on) && !i_select_strobe_en |-> cs_c == (o_write_strobe_n ?
    e1(8'(i_read_setup_cycles)) : e1(8'(i_write_setup_cycles))))
    else $error("setup phase length wrong");
  a_strobe_len: assert property (
    $fell(st_on) && !i_extend_wait_en |-> st_c == (was_wr ?
    e1(8'(i_write_strobe_cycles)) : e1(8'(i_read_strobe_cycles))))
    else $error("strobe length wrong");
  a_hold_len: assert property (
    $fell(cs_on) && !i_select_strobe_en |-> hd_c == (was_wr ?
    e1(8'(i_write_hold_cycles)) : e1(8'(i_read_hold_cycles))))
    else $error("hold length wrong");
  a_select_follow: assert property (
    i_select_strobe_en |-> cs_on == st_on) else $error("select off strobe");
  a_wait_release: assert property (
    $fell(i_ext_wait_in) && i_extend_wait_en && st_on |-> ##4 s_strobe_end)
    else $error("strobe late after wait release");
  a_timeout_end: assert property (
    o_wait_timeout |-> ##2 s_strobe_end) else $error("timeout strobe late");
  a_wdata_held: assert property (
    !o_write_strobe_n |-> !o_mem_data_bus_oe_n && $stable(o_mem_data_bus))
    else $error("write data not held");
  a_rdata_pulse: assert property (
    o_rdata_valid == $rose(o_read_strobe_n)) else $error("read pulse wrong");
endmodule
bind async_memory_phase_sequencer async_mem_seq_sva i_sva (.*);
`default_nettype wire

// file: sim/async_mem_model.sv
// Behavioural asynchronous memory with a wait pin
`timescale 1ns/10ps
`default_nettype none
module async_mem_model (
  input  wire logic        i_core_clk,
  input  wire logic [3:0]  i_chip_select_n,
  input  wire logic        i_read_strobe_n,
  input  wire logic        i_write_strobe_n,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_bus,
  input  wire logic [7:0]  i_wait_len,
  output logic [15:0]      o_data,
  output logic             o_ext_wait_in
);
  logic [15:0] mem [16];
  logic [15:0] pat = 16'h5aa5;
  logic [7:0]  wcnt = 8'h00;
  logic        st_q = 1'b0;
  logic        sel, st;
  assign sel = ~&i_chip_select_n;
  assign st  = !(i_read_strobe_n && i_write_strobe_n);
  // Released bus shows a pattern that flips every clock, never old data
  assign o_data = (sel && !i_read_strobe_n) ? mem[i_addr] : pat;
  // Wait rises one clock into the strobe, far ahead of its normal end
  assign o_ext_wait_in = (wcnt != 8'h00);
  always_ff @(posedge i_core_clk) begin
    pat  <= ~pat;
    st_q <= st;
    if (st && !st_q) wcnt <= i_wait_len;
    else if (wcnt != 8'h00) wcnt <= wcnt - 8'h01;
    if (sel && !i_write_strobe_n) mem[i_addr] <= i_bus;
  end
endmodule
`default_nettype wire

// file: sim/test_async_memory_phase_sequencer.sv
// Self-checking bench for the memory phase sequencer
`timescale 1ns/10ps
`default_nettype none
module test_async_memory_phase_sequencer;
  typedef struct packed {
    logic        wr;
    logic        ss;
    logic [3:0]  s;
    logic [5:0]  t;
    logic [2:0]  h;
    logic [1:0]  ta;
    logic [3:0]  a;
    logic [15:0] d;
    logic [7:0]  len;
  } row_t;
  logic        i_core_clk, i_reset, i_req_valid, i_req_write, i_ext_wait_in;
  logic        i_extend_wait_en, i_select_strobe_en, o_busy;
  logic        o_req_ready, o_rdata_valid, o_wait_timeout;
  logic        o_mem_data_bus_oe_n, o_read_strobe_n, o_write_strobe_n;
  logic [20:0] i_req_addr, o_mem_addr_out;
  logic [1:0]  i_req_bank, i_req_cs_sel, i_turnaround_cycles, o_bank_select_out;
  logic [15:0] i_req_wdata, o_rdata, o_mem_data_bus, i_mem_data_bus, mdat, rd;
  logic [3:0]  i_read_setup_cycles, i_write_setup_cycles, o_chip_select_n, csv;
  logic [5:0]  i_read_strobe_cycles, i_write_strobe_cycles;
  logic [2:0]  i_read_hold_cycles, i_write_hold_cycles;
  logic [7:0]  i_max_wait_limit, wlen;
  logic [1:0]  bnk;
  int          num_errors, samples_checked, lowc, busy, stw, tmo;
  // Phase lengths, turnaround and expected select span for each access
  // Strobes of three clocks or more, as read data crosses two flops
  row_t rows [6] = '{
    '{1'h1, 1'h0, 4'h2, 6'h03, 3'h1, 2'h0, 4'h1, 16'h1234, 8'h06},
    '{1'h0, 1'h0, 4'h2, 6'h03, 3'h1, 2'h0, 4'h1, 16'h1234, 8'h06},
    '{1'h1, 1'h1, 4'h0, 6'h03, 3'h0, 2'h3, 4'h6, 16'hbeef, 8'h05},
    '{1'h0, 1'h1, 4'h0, 6'h03, 3'h0, 2'h3, 4'h6, 16'hbeef, 8'h05},
    '{1'h1, 1'h0, 4'hf, 6'h3f, 3'h7, 2'h1, 4'hf, 16'h8001, 8'h55},
    '{1'h0, 1'h0, 4'hf, 6'h3f, 3'h7, 2'h2, 4'hf, 16'h8001, 8'h55}};
  async_memory_phase_sequencer i_async_memory_phase_sequencer (.*);
  async_mem_model i_async_mem_model (
    .i_core_clk(i_core_clk), .i_chip_select_n(o_chip_select_n),
    .i_read_strobe_n(o_read_strobe_n), .i_write_strobe_n(o_write_strobe_n),
    .i_addr(o_mem_addr_out[3:0]), .i_bus(i_mem_data_bus), .i_wait_len(wlen),
    .o_data(mdat), .o_ext_wait_in(i_ext_wait_in));
  // Data pins carry the design's word only while it drives them
  assign i_mem_data_bus = o_mem_data_bus_oe_n ? mdat : o_mem_data_bus;
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Same lengths for reads and writes; only changed while idle
  task automatic cfg(input logic [3:0] s, input logic [5:0] t,
                     input logic [2:0] h, input logic [1:0] ta, input logic ss);
    @(posedge i_core_clk);
    i_read_setup_cycles   <= s;
    i_write_setup_cycles  <= s;
    i_read_strobe_cycles  <= t;
    i_write_strobe_cycles <= t;
    i_read_hold_cycles    <= h;
    i_write_hold_cycles   <= h;
    i_turnaround_cycles   <= ta;
    i_select_strobe_en    <= ss;
  endtask
  // One access, then count pin activity until ready returns
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_req_valid  <= 1'b1;
    i_req_write  <= w;
    i_req_addr   <= {17'h0, a};
    i_req_bank   <= a[3:2];
    i_req_cs_sel <= a[1:0];
    i_req_wdata  <= d;
    @(posedge i_core_clk);
    i_req_valid <= 1'b0;
    {lowc, busy, stw, tmo, rd, bnk} = '0;
    #1;
    while (!o_req_ready && busy < 2000) begin
      if (~&o_chip_select_n) lowc++;
      if (~&o_chip_select_n) csv = o_chip_select_n;
      if (!(o_read_strobe_n && o_write_strobe_n)) stw++;
      if (!(o_read_strobe_n && o_write_strobe_n)) bnk = o_bank_select_out;
      if (o_wait_timeout) tmo++;
      if (o_rdata_valid) rd = o_rdata;
      @(posedge i_core_clk);
      #1;
      busy++;
    end
    if (busy >= 2000) begin
      chk(32'h0, 32'h1);
      conclude();
    end
  endtask
  initial begin
    {i_reset, i_req_valid, i_req_write, i_req_addr, i_req_bank} = '0;
    {i_req_cs_sel, i_req_wdata, i_extend_wait_en, i_select_strobe_en} = '0;
    {i_read_setup_cycles, i_read_strobe_cycles, i_read_hold_cycles} = '0;
    {i_write_setup_cycles, i_write_strobe_cycles, i_write_hold_cycles} = '0;
    {i_turnaround_cycles, i_max_wait_limit, wlen} = '0;
    {num_errors, samples_checked} = '0;
    i_reset = 1'b1;
    repeat (2) @(posedge i_core_clk);
    #1;
    chk({o_chip_select_n, o_read_strobe_n}, 32'h1f);
    chk({o_req_ready, o_busy}, 32'h1);
    @(posedge i_core_clk);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    #1;
    chk({o_req_ready, o_busy}, 32'h2);
    $display("reset test done");
    foreach (rows[i]) begin
      cfg(rows[i].s, rows[i].t, rows[i].h, rows[i].ta, rows[i].ss);
      acc(rows[i].wr, rows[i].a, rows[i].d);
      chk(busy, rows[i].len + rows[i].ta);
      chk(stw, rows[i].t);
      chk(lowc, rows[i].ss ? 8'(rows[i].t) : rows[i].len);
      chk(csv, 4'(~(4'h1 << rows[i].a[1:0])));
      chk(bnk, rows[i].a[3:2]);
      chk(o_mem_addr_out, {17'h0, rows[i].a});
      if (!rows[i].wr) chk(rd, rows[i].d);
    end
    $display("row table done");
    // Memory holds wait for twenty clocks, on a write then a read
    cfg(4'h1, 6'h08, 3'h1, 2'h0, 1'b0);
    wlen <= 8'h14;
    i_extend_wait_en <= 1'b1;
    for (int w = 1; w >= 0; w--) begin
      acc(w[0], 4'h6, 16'hc3c3);
      chk(stw, 32'h19);
      chk(busy, 32'h1b);
    end
    chk(rd, 16'hc3c3);
    // Wait pin ignored with the mode off, then a wait cut by timeout
    @(posedge i_core_clk);
    i_extend_wait_en <= 1'b0;
    acc(1'b0, 4'h6, 16'h0);
    chk(stw, 32'h8);
    @(posedge i_core_clk);
    i_extend_wait_en <= 1'b1;
    i_max_wait_limit <= 8'h01;
    wlen <= 8'h3c;
    acc(1'b0, 4'h6, 16'h0);
    chk(tmo, 32'h1);
    $display("wait tests done");
    conclude();
  end
endmodule
`default_nettype wire
